/* rtl/cwd_pkg.sv */
// Purpose: Shared constants for the configuration word decoder.
// Assumes: One clock at 20 MHz, synchronous active-high reset.
// Notes:   Addresses are word addresses of the programming port.
package cwd_pkg;

  localparam int          CWD_WORD_W       = 14;
  localparam int          CWD_ADDR_W       = 14;
  localparam int          CWD_PC_W         = 13;

  // Configuration space and the location of the word inside it.
  localparam logic [13:0] CWD_CFG_ADDR     = 14'h2007;
  localparam logic [13:0] CWD_CFG_LO       = 14'h2000;
  localparam logic [13:0] CWD_CFG_HI       = 14'h3fff;

  // Erased word: every bit unprogrammed reads one; bit 9 reads zero.
  localparam logic [13:0] CWD_ERASED       = 14'h3dff;
  localparam logic [13:0] CWD_IMPL_MASK    = 14'h3dff;

  // Field positions.
  localparam int          CWD_CP_HI_HI     = 13;
  localparam int          CWD_CP_HI_LO     = 12;
  localparam int          CWD_CP_LO_HI     = 11;
  localparam int          CWD_CP_LO_LO     = 10;
  localparam int          CWD_UNUSED_BIT   = 9;
  localparam int          CWD_DATA_PROT    = 8;
  localparam int          CWD_LOW_VOLT_BIT = 7;
  localparam int          CWD_BOR_BIT      = 6;
  localparam int          CWD_MCLR_BIT     = 5;
  localparam int          CWD_OSC_B2       = 4;
  localparam int          CWD_PWRT_BIT     = 3;
  localparam int          CWD_WDT_BIT      = 2;
  localparam int          CWD_OSC_B1       = 1;
  localparam int          CWD_OSC_B0       = 0;

  // Code protect select codes.
  localparam logic [1:0]  CWD_CP_OFF       = 2'h3;
  localparam logic [1:0]  CWD_CP_UPPER     = 2'h2;
  localparam logic [1:0]  CWD_CP_HALF      = 2'h1;
  localparam logic [1:0]  CWD_CP_ALL       = 2'h0;

  // Protected range bounds.
  localparam logic [12:0] CWD_BASE_ALL     = 13'h0000;
  localparam logic [12:0] CWD_BASE_HALF    = 13'h0200;
  localparam logic [12:0] CWD_BASE_UPPER   = 13'h0400;
  localparam logic [12:0] CWD_TOP_1K       = 13'h03ff;
  localparam logic [12:0] CWD_TOP_2K       = 13'h07ff;

  // Clock-out is the internal clock divided by this figure.
  localparam int          CWD_CLOCK_OUTPUT_FUNCTION_DIV   = 4;
  localparam logic [1:0]  CWD_DIV_LAST     = 2'(CWD_CLOCK_OUTPUT_FUNCTION_DIV - 1);
  localparam logic [1:0]  CWD_DIV_HALF     = 2'(CWD_CLOCK_OUTPUT_FUNCTION_DIV / 2);

  typedef enum logic [2:0] {
    CWD_OSC_LOW_PWR  = 3'h0,
    CWD_OSC_STD      = 3'h1,
    CWD_OSC_FAST     = 3'h2,
    CWD_OSC_EXT_CLK  = 3'h3,
    CWD_OSC_RC_IO    = 3'h4,
    CWD_OSC_RC_CLK   = 3'h5,
    CWD_OSC_RES_IO   = 3'h6,
    CWD_OSC_RES_CLK  = 3'h7
  } cwd_osc_t;

endpackage : cwd_pkg

/* rtl/cwd_clock_output_function_div.sv */
// Purpose: Divides the internal clock for the clock output function.
// Assumes: Enable is a level held while the function is selected.
// Notes:   Output is held low while disabled.
`timescale 1ns/10ps
`default_nettype none
module cwd_clock_output_function_div
  import cwd_pkg::*;
(
  input  wire logic clk,      // internal clock
  input  wire logic reset,    // synchronous reset, active high
  input  wire logic enable,   // clock output function selected
  output logic      clk_out   // divided clock
);

  typedef struct packed {
    logic [1:0] count;
    logic       level;
  } cwd_div_state_t;

  cwd_div_state_t state;
  cwd_div_state_t next_state;

  always_comb begin
    next_state = state;
    if (!enable) begin
      next_state.count = 2'h0;
      next_state.level = 1'b0;
    end else begin
      next_state.count = (state.count == CWD_DIV_LAST) ? 2'h0
                         : 2'(state.count + 2'h1);
      next_state.level = (next_state.count < CWD_DIV_HALF);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign clk_out = state.level;

endmodule : cwd_clock_output_function_div
`default_nettype wire

/* rtl/cwd_config_word_decode.sv */
// Purpose: Holds the configuration word and decodes it into settings.
// Assumes: Programmer port is active only while prog_mode is high.
// Notes:   Settings are registered; reads answer one cycle later.
//
// Operation
// R01 - Programmed bit zero, erased bit one
// R02 - Word lives at location 2007h
// R03 - Config space reachable only in programming
// R04 - 2K parts: code protect ranges
// R05 - 1K parts: code protect ranges
// R06 - Bit 9 always reads zero
// R07 - Bit 8 zero protects data memory
// R08 - Bit 7 selects low voltage program pin
// R09 - Oscillator select from bits 4,1,0
// R10 - Codes 111/110 external resistor oscillator
// R11 - Codes 101/100 internal RC oscillator
// R12 - Code 011 external clock input
// R13 - Code 010 high speed crystal
// R14 - Resistor mode pin: I/O or clock/4
// R15 - Codes 001/000 standard, low power crystal
// R16 - Brownout, master clear, power timer, watchdog
// R17 - Programmer writes both protect pairs equal
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module cwd_config_word_decode
  import cwd_pkg::*;
#(
  parameter bit MEM_IS_2K = 1'b0          // program memory 2K when set
) (
  input  wire logic        clk,               // clock, 20 MHz
  input  wire logic        reset,             // synchronous, active high
  input  wire logic        prog_mode,         // device in programming mode
  input  wire logic [13:0] addr,              // programming word address
  input  wire logic [13:0] wdata,             // programming write data
  input  wire logic        wr,                // write strobe
  input  wire logic        rd,                // read strobe
  output logic      [13:0] rdata,             // read data, cycle after rd
  input  wire logic [12:0] fetch_addr,        // program memory address
  output logic             fetch_protected,   // fetch_addr is protected
  output logic             code_protect_on,   // any code protection active
  output logic      [12:0] protect_base,      // lowest protected address
  output logic      [12:0] protect_top,       // highest protected address
  output logic             code_protect_mismatch, // pairs differ
  output logic             data_memory_protect,   // data memory protected
  output logic             low_volt_prog_enable,  // program pin function
  output logic             low_volt_program_pin_is_io, // pin is digital I/O
  output logic             hv_program_entry_only, // high voltage entry
  output logic             brownout_reset_enable, // brown-out reset on
  output logic             master_clear_pin_select, // pin is master clear
  output logic             power_up_timer_enable, // power-up timer on
  output logic             watchdog_enable,     // watchdog on
  output logic      [2:0]  osc_select,          // oscillator code
  output logic             ext_resistor_oscillator, // resistor mode
  output logic             internal_rc_osc,     // internal RC mode
  output logic             external_clock_input_mode, // external clock
  output logic             high_speed_crystal_mode,   // fast crystal
  output logic             standard_crystal_mode,     // standard crystal
  output logic             low_power_crystal_mode,    // low power crystal
  output logic             clock_input_pin_is_io,     // first pin is I/O
  output logic             osc2_pin_is_io,      // second pin is I/O
  output logic             clock_output_function, // second pin drives clk
  output logic             clock_output         // internal clock / 4
);

  typedef struct packed {
    logic [13:0] word;
    logic [13:0] rdata;
    logic        cp_on;
    logic [12:0] base;
    logic [12:0] top;
    logic        mismatch;
    logic        fetch_prot;
    logic        data_prot;
    logic        low_volt;
    logic        bor;
    logic        mclr;
    logic        pwrt;
    logic        wdt;
    logic [2:0]  osc;
  } cwd_state_t;

  cwd_state_t state;
  cwd_state_t next_state;

  always_comb begin
    logic        in_cfg;
    logic [1:0]  cp_hi;
    logic [1:0]  cp_lo;
    logic [12:0] base;
    logic        on;
    in_cfg = 1'b0;
    cp_hi  = 2'h0;
    cp_lo  = 2'h0;
    base   = CWD_BASE_ALL;
    on     = 1'b0;
    next_state = state;
    in_cfg = prog_mode && addr >= CWD_CFG_LO && addr <= CWD_CFG_HI; // R03
    if (in_cfg && wr && addr == CWD_CFG_ADDR) begin // R02
      next_state.word = wdata & CWD_IMPL_MASK; // R06
    end
    next_state.rdata = 14'h0000;
    if (in_cfg && rd && addr == CWD_CFG_ADDR) begin // R02
      next_state.rdata = state.word & CWD_IMPL_MASK; // R06
    end
    // Protection decodes the bitwise AND of both pairs; on a mismatch
    // a select bit reads zero when either pair has it zero.
    cp_hi = {state.word[CWD_CP_HI_HI], state.word[CWD_CP_HI_LO]};
    cp_lo = {state.word[CWD_CP_LO_HI], state.word[CWD_CP_LO_LO]};
    next_state.mismatch = (cp_hi != cp_lo); // R17
    next_state.top = MEM_IS_2K ? CWD_TOP_2K : CWD_TOP_1K;
    case ((cp_hi & cp_lo))
      CWD_CP_OFF: begin
        on = 1'b0;
      end
      CWD_CP_UPPER: begin
        on   = MEM_IS_2K; // R05
        base = CWD_BASE_UPPER; // R04
      end
      CWD_CP_HALF: begin
        on   = 1'b1;
        base = CWD_BASE_HALF; // R04 R05
      end
      CWD_CP_ALL: begin
        on   = 1'b1;
        base = CWD_BASE_ALL; // R04 R05
      end
      default: begin
        on = 1'b0;
      end
    endcase
    next_state.cp_on = on;
    next_state.base  = base;
    next_state.fetch_prot = on && fetch_addr >= base
                            && fetch_addr <= next_state.top;
    next_state.data_prot = ~state.word[CWD_DATA_PROT]; // R07
    next_state.low_volt = state.word[CWD_LOW_VOLT_BIT]; // R08
    next_state.bor  = state.word[CWD_BOR_BIT]; // R16
    next_state.mclr = state.word[CWD_MCLR_BIT]; // R16
    next_state.pwrt = ~state.word[CWD_PWRT_BIT]; // R16
    next_state.wdt  = state.word[CWD_WDT_BIT]; // R16
    next_state.osc  = {state.word[CWD_OSC_B2], state.word[CWD_OSC_B1],
                       state.word[CWD_OSC_B0]}; // R09
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state      <= '0;
      state.word <= CWD_ERASED; // R01
      state.top  <= MEM_IS_2K ? CWD_TOP_2K : CWD_TOP_1K;
      state.low_volt <= 1'b1; // R01
      state.bor  <= 1'b1;
      state.mclr <= 1'b1;
      state.wdt  <= 1'b1;
      state.osc  <= 3'h7;
    end else begin
      state <= next_state;
    end
  end

  logic     clk_div_en;
  cwd_osc_t osc_mode;

  assign osc_mode = cwd_osc_t'(state.osc);

  always_comb begin
    ext_resistor_oscillator   = 1'b0;
    internal_rc_osc           = 1'b0;
    external_clock_input_mode = 1'b0;
    high_speed_crystal_mode   = 1'b0;
    standard_crystal_mode     = 1'b0;
    low_power_crystal_mode    = 1'b0;
    clock_input_pin_is_io     = 1'b0;
    osc2_pin_is_io            = 1'b0;
    clock_output_function     = 1'b0;
    case (osc_mode)
      CWD_OSC_RES_CLK: begin
        ext_resistor_oscillator = 1'b1; // R10
        clock_output_function   = 1'b1; // R14
      end
      CWD_OSC_RES_IO: begin
        ext_resistor_oscillator = 1'b1; // R10
        osc2_pin_is_io          = 1'b1; // R14
      end
      CWD_OSC_RC_CLK: begin
        internal_rc_osc       = 1'b1; // R11
        clock_input_pin_is_io = 1'b1;
        clock_output_function = 1'b1;
      end
      CWD_OSC_RC_IO: begin
        internal_rc_osc       = 1'b1; // R11
        clock_input_pin_is_io = 1'b1;
        osc2_pin_is_io        = 1'b1;
      end
      CWD_OSC_EXT_CLK: begin
        external_clock_input_mode = 1'b1; // R12
        osc2_pin_is_io            = 1'b1;
      end
      CWD_OSC_FAST: begin
        high_speed_crystal_mode = 1'b1; // R13
      end
      CWD_OSC_STD: begin
        standard_crystal_mode = 1'b1; // R15
      end
      CWD_OSC_LOW_PWR: begin
        low_power_crystal_mode = 1'b1; // R15
      end
      default: begin
        osc2_pin_is_io = 1'b0;
      end
    endcase
  end

  assign clk_div_en = clock_output_function;

  cwd_clock_output_function_div u_clock_output_function_div (
    .clk     (clk),
    .reset   (reset),
    .enable  (clk_div_en),
    .clk_out (clock_output) // R14
  );

  assign rdata                      = state.rdata;
  assign fetch_protected            = state.fetch_prot;
  assign code_protect_on            = state.cp_on;
  assign protect_base               = state.base;
  assign protect_top                = state.top;
  assign code_protect_mismatch      = state.mismatch;
  assign data_memory_protect        = state.data_prot;
  assign low_volt_prog_enable       = state.low_volt;
  assign low_volt_program_pin_is_io = ~state.low_volt; // R08
  assign hv_program_entry_only      = ~state.low_volt; // R08
  assign brownout_reset_enable      = state.bor;
  assign master_clear_pin_select    = state.mclr;
  assign power_up_timer_enable      = state.pwrt;
  assign watchdog_enable            = state.wdt;
  assign osc_select                 = state.osc;

endmodule : cwd_config_word_decode
`default_nettype wire

/* verification/cwd_assertions.sv */
// Purpose: Port checks for the configuration word decoder.
// Assumes: Bound to the decoder; settings follow the word read back.
// Notes:   One clock domain, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module cwd_assertions
  import cwd_pkg::*;
(
  input wire logic        clk,                        // clock
  input wire logic        reset,                      // reset
  input wire logic        prog_mode,                  // programming
  input wire logic [13:0] addr,                       // address
  input wire logic        rd,                         // read strobe
  input wire logic [13:0] rdata,                      // read data
  input wire logic [2:0]  osc_select,                 // osc code
  input wire logic        data_memory_protect,        // data protect
  input wire logic        low_volt_prog_enable,       // low volt entry
  input wire logic        low_volt_program_pin_is_io, // pin is I/O
  input wire logic        brownout_reset_enable,      // brown-out
  input wire logic        master_clear_pin_select,    // master clear
  input wire logic        power_up_timer_enable,      // power timer
  input wire logic        watchdog_enable,            // watchdog
  input wire logic        code_protect_mismatch,      // pairs differ
  input wire logic        ext_resistor_oscillator,    // resistor osc
  input wire logic        internal_rc_osc,            // rc osc
  input wire logic        clock_input_pin_is_io,      // first pin I/O
  input wire logic        osc2_pin_is_io,             // second pin I/O
  input wire logic        clock_output_function,      // clock out on
  input wire logic        clock_output                // divided clock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence rd_ok;
    rd && prog_mode && addr == CWD_CFG_ADDR;
  endsequence
  idle_read_zero_a: assert property (!rd |=> rdata == 14'h0)
    else $error("read data not zero outside a read");
  refused_read_a: assert property (rd && !prog_mode |=> rdata == 14'h0)
    else $error("read outside programming returned data");
  bit9_low_a: assert property (rdata[9] == 1'b0)
    else $error("bit 9 read as one");
  data_prot_a: assert property (rd_ok |=> data_memory_protect == !rdata[8])
    else $error("data protect differs from bit 8");
  low_volt_pin_a: assert property (rd_ok |=> low_volt_prog_enable == rdata[7]
    && low_volt_program_pin_is_io == !rdata[7]) else $error("pin decode");
  osc_code_a: assert property (rd_ok |=> osc_select == {rdata[4], rdata[1:0]})
    else $error("oscillator code assembled wrongly");
  misc_bits_a: assert property (rd_ok |=> {brownout_reset_enable,
    master_clear_pin_select, power_up_timer_enable, watchdog_enable} ==
    {rdata[6], rdata[5], !rdata[3], rdata[2]}) else $error("misc bits");
  pair_flag_a: assert property (rd_ok |=> code_protect_mismatch ==
    (rdata[13:12] != rdata[11:10])) else $error("pair mismatch flag");
  er_mode_a: assert property (osc_select[2:1] == 2'h3 |->
    ext_resistor_oscillator && !clock_input_pin_is_io &&
    osc2_pin_is_io != clock_output_function) else $error("resistor mode");
  rc_mode_a: assert property (osc_select[2:1] == 2'h2 |-> internal_rc_osc
    && clock_input_pin_is_io && clock_output_function == osc_select[0])
    else $error("internal rc mode");
  clk_div_a: assert property (clock_output_function && $rose(clock_output)
    |=> (clock_output || !clock_output_function) ##1 !clock_output[*2])
    else $error("clock output not divided by four");
  cover property (rd_ok);
  cover property (clock_output_function && $rose(clock_output));
  cover property (code_protect_mismatch);
endmodule : cwd_assertions
bind cwd_config_word_decode cwd_assertions u_chk (.*);
`default_nettype wire

/* verification/cwd_programmer.sv */
// Purpose: Device programmer model driving the programming port.
// Assumes: Requests change right after a rising edge.
// Notes:   Released address and data show the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none
module cwd_programmer (
  input  wire logic        clk,       // clock
  input  wire logic [13:0] rdata,     // read data
  output var  logic        prog_mode, // programming mode
  output var  logic [13:0] addr,      // word address
  output var  logic [13:0] wdata,     // write data
  output var  logic        wr,        // write strobe
  output var  logic        rd         // read strobe
);
  initial begin
    {prog_mode, wr, rd} = 3'h0;
    {addr, wdata} = 28'h0;
  end
  task automatic mode(input logic m);
    @(posedge clk);
    prog_mode <= m;
  endtask : mode
  task automatic write_word(input logic [13:0] a, d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    {wr, addr, wdata} <= {1'b0, ~a, ~d};
  endtask : write_word
  task automatic read_word(input logic [13:0] a, output logic [13:0] d);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    {rd, addr} <= {1'b0, ~a};
    @(negedge clk);
    d = rdata;
  endtask : read_word
endmodule : cwd_programmer
`default_nettype wire

/* verification/tb.sv */
// Purpose: Self-checking bench for the configuration word decoder.
// Assumes: 2K part; programmer model drives the port.
// Notes:   Settings are sampled two edges after each write.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cwd_pkg::*;
  localparam bit MEM2K = 1'b1;
  logic clk = 1'b0, reset = 1'b1, prog_mode, wr, rd, on;
  logic [13:0] addr, wdata, rdata, w, d;
  logic [12:0] fetch_addr = 13'h0, protect_base, protect_top, base, top;
  logic fprot, cp_on, cp_mm, dprot, lv_en, lv_io, hv_only;
  logic bor, mclr, pwrt, wdt, res_osc, rc, ext_clk, fast_x, std_x, low_x;
  logic ci_io, o2_io;
  logic clko_fn, clko;
  logic [2:0] osc_select;
  logic [12:0] fa [4] = '{13'h1ff, 13'h200, 13'h3ff, 13'h400};
  int num_errors = 0, n_checks = 0, cnt;
  always #25 clk = ~clk;
  cwd_programmer prog (.clk(clk), .rdata(rdata), .prog_mode(prog_mode),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  cwd_config_word_decode #(.MEM_IS_2K(MEM2K)) uut (.clk(clk),
    .reset(reset), .prog_mode(prog_mode), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .fetch_addr(fetch_addr),
    .fetch_protected(fprot), .code_protect_on(cp_on),
    .protect_base(protect_base), .protect_top(protect_top),
    .code_protect_mismatch(cp_mm), .data_memory_protect(dprot),
    .low_volt_prog_enable(lv_en), .low_volt_program_pin_is_io(lv_io),
    .hv_program_entry_only(hv_only), .brownout_reset_enable(bor),
    .master_clear_pin_select(mclr), .power_up_timer_enable(pwrt),
    .watchdog_enable(wdt), .osc_select(osc_select),
    .ext_resistor_oscillator(res_osc), .internal_rc_osc(rc),
    .external_clock_input_mode(ext_clk), .high_speed_crystal_mode(fast_x),
    .standard_crystal_mode(std_x), .low_power_crystal_mode(low_x),
    .clock_input_pin_is_io(ci_io), .osc2_pin_is_io(o2_io),
    .clock_output_function(clko_fn), .clock_output(clko));
  task automatic check(input logic [13:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic put_word(input logic [13:0] v);
    prog.write_word(CWD_CFG_ADDR, v);
    repeat (2) @(negedge clk);
  endtask : put_word
  task automatic read_expect(input logic [13:0] a, exp);
    prog.read_word(a, d);
    check(d, exp);
  endtask : read_expect
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    prog.mode(1'b1);
    read_expect(CWD_CFG_ADDR, 14'h3dff);
    put_word(14'h3fff);
    read_expect(CWD_CFG_ADDR, 14'h3dff);
    put_word(14'h0);
    prog.write_word(14'h2006, 14'h3fff);
    read_expect(14'h2006, 14'h0);
    prog.mode(1'b0);
    put_word(14'h3dff);
    read_expect(CWD_CFG_ADDR, 14'h0);
    prog.mode(1'b1);
    read_expect(CWD_CFG_ADDR, 14'h0);
    for (int c = 0; c < 8; c++) begin
      w = 14'h3dec | {c[2], 2'b0, c[1:0]};
      if (c[0]) w = w ^ 14'h01ec;
      put_word(w);
      check({osc_select, res_osc, rc, ext_clk, fast_x, std_x, low_x},
        {c[2:0], c[2:1] == 2'h3,
        c[2:1] == 2'h2, c == 3, c == 2, c == 1, c == 0});
      check({ci_io, o2_io, clko_fn}, {c[2:1] == 2'h2,
        c == 6 || c == 4 || c == 3, c == 7 || c == 5});
      check({dprot, lv_en, lv_io, hv_only, bor, mclr, pwrt, wdt}, {!w[8],
        w[7], !w[7], !w[7], w[6], w[5], !w[3], w[2]});
      read_expect(CWD_CFG_ADDR, w);
      cnt = 0;
      repeat (8) begin
        @(negedge clk);
        cnt += clko;
      end
      check(14'(cnt), (c == 7 || c == 5) ? 14'h4 : 14'h0);
    end
    for (int cp = 0; cp < 4; cp++) begin
      put_word({cp[1:0], cp[1:0], 10'h1ff});
      on = MEM2K ? cp != 3 : cp < 2;
      base = cp == 2 ? 13'h400 : cp == 1 ? 13'h200 : 13'h0;
      top = MEM2K ? 13'h7ff : 13'h3ff;
      check({cp_on, cp_mm}, {on, 1'b0});
      if (on) check({1'b0, protect_base}, {1'b0, base});
      if (on) check({1'b0, protect_top}, {1'b0, top});
      foreach (fa[i]) begin
        @(posedge clk);
        fetch_addr <= fa[i];
        @(posedge clk);
        @(negedge clk);
        check(fprot, on && fa[i] >= base && fa[i] <= top);
      end
    end
    put_word(14'h35ff);
    check({cp_on, cp_mm}, 2'h3);
    check({1'b0, protect_base}, 14'h0200);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    read_expect(CWD_CFG_ADDR, 14'h3dff);
    results();
  end
endmodule : tb
`default_nettype wire
